// *** hw/adcts_top.sv ***
// Purpose: APB-reached trigger-source select for four ADC sample sequencers
// Assumes: All trigger inputs synchronous to pclk, single-cycle pulses or levels
// Notes:   Start outputs are registered, one cycle after the chosen source
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module adcts_top
    import adcts_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    // APB slave
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Trigger sources
    input  wire logic [3:0]        soft_req,
    input  wire logic              comp0_trig,
    input  wire logic              external_trigger_pin,
    input  wire logic              timer_trig,
    input  wire logic [2:0]        pwm_trig,
    // Sequencer starts
    output logic [3:0]             seq_start
);
    // Refused at elaboration: the decode needs the full 12-bit offset
    if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr_w
        $error("adcts_top: ADDR_W must be 12..32");
    end

    function automatic logic [3:0] field_of(input logic [31:0] word, input int lsb);
        field_of = word[lsb +: SEL_W];
    endfunction

    logic [31:0]  sel_reg, sel_next;
    logic [31:0]  rdata_reg, rdata_next;
    logic         err_reg, err_next;
    logic [3:0]   start_reg, start_next;
    adcts_state_t state_reg, state_next;
    logic [3:0]   mux_start;
    logic [3:0]   mux_valid;
    logic         hit_sel, hit_stat, setup;
    logic [31:0]  paddr_ext;

    // Widened so the upper-bit check holds for every legal ADDR_W, 12 included
    assign paddr_ext = 32'(paddr);
    assign setup     = psel && !penable;
    assign hit_sel   = paddr_ext == 32'(TRIG_SEL_OFFSET);
    assign hit_stat  = paddr_ext == 32'(TRIG_STAT_OFFSET);

    // Zero-wait slave: the access phase always completes at once
    assign pready  = 1'b1;
    assign prdata  = rdata_reg;
    assign pslverr = err_reg;

    always_comb begin
        state_next = state_reg;
        sel_next   = sel_reg;
        rdata_next = rdata_reg;
        err_next   = err_reg;
        case (state_reg)
            ADCTS_IDLE: begin
                if (setup) begin
                    state_next = ADCTS_ACCESS;
                    err_next   = !(hit_sel || (hit_stat && !pwrite));
                    rdata_next = 32'h0000_0000;
                    if (!pwrite && hit_sel) begin
                        rdata_next = sel_reg;
                    end else if (!pwrite && hit_stat) begin
                        rdata_next = {28'h000_0000, mux_valid};
                    end
                end
            end
            ADCTS_ACCESS: begin
                // Write commits only at the completing access edge
                if (psel && penable && pwrite && hit_sel) begin
                    for (int b = 0; b < 2; b++) begin
                        if (pstrb[b]) begin
                            sel_next[b*8 +: 8] = pwdata[b*8 +: 8];
                        end
                    end
                    sel_next[31:SEL_FIELD_BITS] = 16'h0000;
                end
                state_next = ADCTS_IDLE;
            end
            default: state_next = ADCTS_IDLE;
        endcase
    end

    // One mux per sequencer; reserved codes fall to no source
    for (genvar s = 0; s < NUM_SEQ; s++) begin : g_mux
        adcts_trig_mux u_mux (
            .sel        (field_of(sel_reg, s * SEL_W)),
            .soft_req   (soft_req[s]),
            .comp0_trig (comp0_trig),
            .ext_trig   (external_trigger_pin),
            .timer_trig (timer_trig),
            .pwm_trig   (pwm_trig),
            .start      (mux_start[s]),
            .sel_valid  (mux_valid[s])
        );
    end

    always_comb begin
        start_next = mux_start;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ADCTS_IDLE;
            sel_reg   <= TRIG_SEL_RESET;
            rdata_reg <= 32'h0000_0000;
            err_reg   <= 1'b0;
            start_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            sel_reg   <= sel_next;
            rdata_reg <= rdata_next;
            err_reg   <= err_next;
            start_reg <= start_next;
        end
    end

    assign seq_start = start_reg;

    a_always_mode: assert property (@(posedge pclk) disable iff (!presetn)
        sel_reg[3:0] == 4'hF |=> seq_start[0])
        else $error("continuous mode did not start sequencer 0");
    a_ext_route: assert property (@(posedge pclk) disable iff (!presetn)
        sel_reg[11:8] == 4'h4 |=> seq_start[2] == $past(external_trigger_pin))
        else $error("sequencer 2 not following external pin");
    a_timer_route: assert property (@(posedge pclk) disable iff (!presetn)
        sel_reg[7:4] == 4'h5 |=> seq_start[1] == $past(timer_trig))
        else $error("sequencer 1 not following timer");
    a_pwm2_route: assert property (@(posedge pclk) disable iff (!presetn)
        sel_reg[15:12] == 4'h8 |=> seq_start[3] == $past(pwm_trig[2]))
        else $error("sequencer 3 not following pwm 2");
    a_pwm_route: assert property (@(posedge pclk) disable iff (!presetn)
        sel_reg[3:0] == 4'h6 |=> seq_start[0] == $past(pwm_trig[0]))
        else $error("sequencer 0 not following pwm 0");
    a_soft_route: assert property (@(posedge pclk) disable iff (!presetn)
        sel_reg[3:0] == 4'h0 |=> seq_start[0] == $past(soft_req[0]))
        else $error("sequencer 0 not following software request");
    a_comp_route: assert property (@(posedge pclk) disable iff (!presetn)
        sel_reg[7:4] == 4'h1 |=> seq_start[1] == $past(comp0_trig))
        else $error("sequencer 1 not following comparator");
    a_reserved_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (sel_reg[11:8] == 4'h2 || sel_reg[11:8] == 4'hA) |=> !seq_start[2])
        else $error("reserved code produced a start");
    a_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pwrite && hit_sel && pstrb[0] && state_reg == ADCTS_ACCESS
        |=> sel_reg[7:0] == $past(pwdata[7:0]))
        else $error("write to select register lost");

    c_write: cover property (@(posedge pclk) psel && penable && pwrite && hit_sel);
    c_read: cover property (@(posedge pclk) psel && penable && !pwrite && hit_sel);
    c_always: cover property (@(posedge pclk) sel_reg[15:12] == 4'hF);
    c_bad_addr: cover property (@(posedge pclk) psel && penable && pslverr);
endmodule

// *** hw/adcts_pkg.sv ***
// Purpose: Shared constants for the sequencer trigger-select block
// Assumes: APB, 32-bit data, one word per register
// Notes:   Register offsets are byte addresses
package adcts_pkg;
    localparam int          NUM_SEQ          = 4;
    localparam int          SEL_W            = 4;
    localparam logic [11:0] TRIG_SEL_OFFSET  = 12'h014;
    localparam logic [11:0] TRIG_STAT_OFFSET = 12'h018;
    localparam logic [31:0] TRIG_SEL_RESET   = 32'h0000_0000;
    localparam int          SEQ0_LSB         = 0;
    localparam int          SEQ1_LSB         = 4;
    localparam int          SEQ2_LSB         = 8;
    localparam int          SEQ3_LSB         = 12;
    localparam int          SEL_FIELD_BITS   = 16;

    typedef enum logic [3:0] {
        ADCTS_SRC_SOFT   = 4'h0,
        ADCTS_SRC_COMP0  = 4'h1,
        ADCTS_SRC_EXT    = 4'h4,
        ADCTS_SRC_TIMER  = 4'h5,
        ADCTS_SRC_PWM0   = 4'h6,
        ADCTS_SRC_PWM1   = 4'h7,
        ADCTS_SRC_PWM2   = 4'h8,
        ADCTS_SRC_ALWAYS = 4'hF
    } adcts_src_t;

    typedef enum logic [1:0] {
        ADCTS_IDLE   = 2'b01,
        ADCTS_ACCESS = 2'b10
    } adcts_state_t;
endpackage

// *** hw/adcts_trig_mux.sv ***
// Purpose: Trigger mux for one sample sequencer
// Assumes: Trigger sources are synchronous to pclk
// Notes:   Reserved codes select no source
`timescale 1ns/1ps
module adcts_trig_mux
    import adcts_pkg::*;
(
    // Selection
    input  wire logic [3:0] sel,
    // Sources
    input  wire logic       soft_req,
    input  wire logic       comp0_trig,
    input  wire logic       ext_trig,
    input  wire logic       timer_trig,
    input  wire logic [2:0] pwm_trig,
    // Result
    output logic            start,
    output logic            sel_valid
);
    always_comb begin
        start     = 1'b0;
        sel_valid = 1'b1;
        case (sel)
            ADCTS_SRC_SOFT:   start = soft_req;
            ADCTS_SRC_COMP0:  start = comp0_trig;
            ADCTS_SRC_EXT:    start = ext_trig;
            // Timer pulses only arrive once its own output trigger is enabled
            ADCTS_SRC_TIMER:  start = timer_trig;
            ADCTS_SRC_PWM0:   start = pwm_trig[0];
            ADCTS_SRC_PWM1:   start = pwm_trig[1];
            ADCTS_SRC_PWM2:   start = pwm_trig[2];
            ADCTS_SRC_ALWAYS: start = 1'b1;
            default: begin
                start     = 1'b0;
                sel_valid = 1'b0;
            end
        endcase
    end
endmodule

// *** tb/adcts_src_model.sv ***
// Purpose: Trigger source model for the sequencer trigger select
// Assumes: Sources change just after pclk edges
// Notes:   Timer pulses stay local unless its output trigger is enabled
`timescale 1ns/1ps
module adcts_src_model (
    // Clock
    input  wire logic       pclk,
    // Timer control
    input  wire logic       timer_output_trigger_enable,
    // Sources
    output logic            comp0_trig,
    output logic            external_trigger_pin,
    output logic            timer_trig,
    output logic [2:0]      pwm_trig
);
    integer      seed = 41;
    logic [31:0] r;
    initial {comp0_trig, external_trigger_pin, timer_trig, pwm_trig} = 6'h00;
    always @(posedge pclk) begin
        r = $random(seed);
        comp0_trig <= r[0];
        external_trigger_pin <= r[1];
        timer_trig <= r[2] & timer_output_trigger_enable;
        pwm_trig <= r[5:3];
    end
endmodule

// *** tb/tb.sv ***
// Purpose: Self-checking bench for the sequencer trigger select
// Assumes: Zero-wait APB slave, registered starts one cycle late
// Notes:   Shadow register predicts read data, status and starts
`timescale 1ns/1ps
module tb
    import adcts_pkg::*;
;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic        timer_output_trigger_enable = 0, comp0_trig, external_trigger_pin;
    logic        timer_trig, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd, shadow = 32'h0, r, q, prdata;
    logic [3:0]  pstrb = 4'h0, soft_req = 4'h0, seq_start, exp_start = 4'h0;
    logic [2:0]  pwm_trig;
    integer      seed = 41, miscompares = 0, n_compared = 0, cyc = 0;
    always #5 pclk = ~pclk;
    adcts_top #(.ADDR_W(12)) i_adcts_top (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .soft_req, .comp0_trig,
        .external_trigger_pin, .timer_trig, .pwm_trig, .seq_start);
    adcts_src_model i_adcts_src_model (.pclk, .timer_output_trigger_enable,
        .comp0_trig, .external_trigger_pin, .timer_trig, .pwm_trig);
    function logic pick(logic [3:0] c, int s);
        case (c)
            4'h0: pick = soft_req[s];
            4'h1: pick = comp0_trig;
            4'h4: pick = external_trigger_pin;
            4'h5: pick = timer_trig;
            4'h6, 4'h7, 4'h8: pick = pwm_trig[2'(c - 4'h6)];
            4'hF: pick = 1'b1;
            default: pick = 1'b0;
        endcase
    endfunction
    function logic [31:0] stat(logic [31:0] v);
        stat = 32'h0;
        for (int s = 0; s < 4; s++) stat[s] = v[4*s+:4] inside {4'h0, 4'h1, [4'h4:4'h8], 4'hF};
    endfunction
    task check(string what, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task summarize;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Starts on a fresh edge so psel is never assigned twice in one step
    task apb(logic w, logic [11:0] a, logic [31:0] d, logic [3:0] st);
        int g;
        g = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, st};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            g++;
        end while (pready !== 1'b1 && g < 50);
        rd = prdata;
        err = pslverr;
        check("pready", {31'h0, pready}, 32'h1);
        if (g >= 50) miscompares++;
        if (w && a == TRIG_SEL_OFFSET)
            shadow <= {16'h0, st[1] ? d[15:8] : shadow[15:8], st[0] ? d[7:0] : shadow[7:0]};
        {psel, penable} <= 2'b00;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (presetn) check("seq_start", {28'h0, seq_start}, {28'h0, exp_start});
        for (int s = 0; s < 4; s++) exp_start[s] <= presetn & pick(shadow[4*s+:4], s);
        q = $random(seed);
        soft_req <= q[3:0];
        timer_output_trigger_enable <= q[4];
        if (cyc > 5000) begin
            miscompares++;
            summarize();
        end
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, TRIG_SEL_OFFSET, 0, 0);
        check("sel reset", rd, TRIG_SEL_RESET);
        for (int i = 0; i < 48; i++) begin
            r = (i < 16) ? {16'h0, 4'(i + 3), 4'(i + 2), 4'(i + 1), 4'(i)} : $random(seed);
            apb(1, TRIG_SEL_OFFSET, r, (i < 16) ? 4'hF : r[19:16]);
            apb(0, TRIG_SEL_OFFSET, 0, 0);
            check("sel", rd, shadow);
            check("sel err", {31'h0, err}, 32'h0);
            apb(0, TRIG_STAT_OFFSET, 0, 0);
            check("status", rd, stat(shadow));
            repeat (4) @(posedge pclk);
        end
        apb(0, 12'h01C, 0, 0);
        check("unmapped", {err, rd[30:0]}, 32'h80000000);
        apb(1, TRIG_STAT_OFFSET, 32'hFFFF, 4'hF);
        check("status write", {31'h0, err}, 32'h1);
        apb(0, TRIG_SEL_OFFSET, 0, 0);
        check("sel kept", rd, shadow);
        presetn <= 1'b0;
        shadow <= 32'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, TRIG_SEL_OFFSET, 0, 0);
        check("sel rereset", rd, TRIG_SEL_RESET);
        summarize();
    end
endmodule
